// ---- hw/qaw_event_evaluator.sv ----
// Q&A watchdog sequence evaluator with APB register access
//
// Implementation choices: the APB register port and the register offsets.
`include "qaw_params.svh"
`timescale 1ns/100ps
`default_nettype none
module qaw_event_evaluator #(
    parameter int WIN_STEP_CYC = `QAW_WIN_STEP_CYC
) (
    input  wire logic              clk_sys,   // System clock, 100 MHz
    input  wire logic              reset_n,   // Async reset, active low
    input  wire logic              psel,      // APB select
    input  wire logic              penable,   // APB access phase
    input  wire logic              pwrite,    // APB direction
    input  wire logic [7:0]        paddr,     // APB byte address
    input  wire logic [31:0]       pwdata,    // APB write data
    output logic                   pready,    // APB ready
    output logic [31:0]            prdata,    // APB read data
    output logic                   pslverr,   // APB error, unmapped address
    output logic                   irq,       // Level interrupt
    output qaw_pkg::qaw_nibble_t   question   // Current question
);
    import qaw_pkg::*;

    // Only the default feedback table is held; feedback choice moves questions, not answers
    // Reference answer byte: row from table, nibbles inverted per counter bit
    function automatic qaw_byte_t ref_answer(input qaw_nibble_t q, input logic [1:0] cnt);
        qaw_byte_t base;
        base = 8'h00;
        case (q)
            4'h0: base = 8'hff;
            4'h1: base = 8'hb0;
            4'h2: base = 8'he9;
            4'h3: base = 8'ha6;
            4'h4: base = 8'h75;
            4'h5: base = 8'h3a;
            4'h6: base = 8'h63;
            4'h7: base = 8'h2c;
            4'h8: base = 8'hd2;
            4'h9: base = 8'h9d;
            4'ha: base = 8'hc4;
            4'hb: base = 8'h8b;
            4'hc: base = 8'h58;
            4'hd: base = 8'h17;
            4'he: base = 8'h4e;
            default: base = 8'h01;
        endcase
        return base ^ {{4{~cnt[0]}}, {4{~cnt[1]}}};
    endfunction : ref_answer

    // Markov chain step; zero is the special seed that counts as one
    function automatic qaw_nibble_t markov_step(input qaw_nibble_t x, input logic [1:0] fb);
        qaw_nibble_t s;
        logic        bitIn;
        s = (x == 4'h0) ? 4'h1 : x;
        bitIn = 1'b0;
        case (fb)
            2'h0: bitIn = s[3] ^ s[2];
            2'h1: bitIn = s[3] ^ s[1];
            2'h2: bitIn = s[2] ^ s[1];
            default: bitIn = s[3] ^ s[2] ^ s[1];
        endcase
        return {s[2:0], bitIn};
    endfunction : markov_step

    // Saturating fail counter step
    function automatic logic [2:0] fail_step(input logic [2:0] v, input logic up);
        if (up) begin
            return (v == 3'h7) ? v : v + 3'h1;
        end
        return (v == 3'h0) ? v : v - 3'h1;
    endfunction : fail_step

    // Software-visible configuration
    logic [7:0]  openLen;
    logic [7:0]  closeLen;
    logic [1:0]  questionFeedbackSelect;
    logic        cfgLock;
    logic [3:0]  irqEnable;
    logic [3:0]  irqStatus;

    // Sequence state
    logic [1:0]  answerByteCounter;
    logic        answerErr;
    logic [2:0]  sequenceFailCounter;
    logic        sequenceErrorFlag;
    logic        windowConfigChangedFlag;
    logic        timeoutFlag;
    logic        earlyFlag;
    logic [3:0]  tokenCnt;
    logic [3:0]  markov;
    logic [15:0] stepCnt;
    logic [9:0]  winTicks;
    logic [3:0]  next_tokenCnt;
    logic [3:0]  next_markov;

    // Decode of the current access
    logic        accessWr;
    logic        answerWr;
    logic        windowWr;
    logic        mismatch;
    logic        errNext;
    logic        inOpen;
    logic        timeoutHit;
    logic [9:0]  tickLimit;
    logic        mapped;
    logic [31:0] next_rdata;
    qaw_event_e  evKind;

    // No wait states: read data is registered in setup, answered in access
    assign pready = psel & penable;

    // Interrupt is a level while any enabled sticky bit stands
    assign irq = |(irqStatus & irqEnable);

    // Access decode and window position
    always_comb begin
        accessWr  = psel & penable & pwrite;
        answerWr  = accessWr && (paddr == `QAW_ADDR_ANSWER);
        windowWr  = accessWr && ((paddr == `QAW_ADDR_OPENWIN) ||
                                 (paddr == `QAW_ADDR_CLOSEWIN));
        mismatch  = answerWr && (pwdata[7:0] != ref_answer(question, answerByteCounter));
        errNext   = answerErr | mismatch;
        inOpen    = winTicks <= {2'h0, openLen};
        tickLimit = {2'h0, openLen} + {2'h0, closeLen} + 10'h2;
        timeoutHit = winTicks >= tickLimit;
    end

    // Only the byte taken with the counter at zero ends a sequence, as good or as bad
    // Event classification; a window write outranks the final byte and time-out
    always_comb begin
        evKind = QAW_EV_NONE;
        if (windowWr) begin
            evKind = QAW_EV_CFG;
        end else if (answerWr && answerByteCounter == 2'h0) begin
            if (!errNext && !inOpen) begin
                evKind = QAW_EV_GOOD;
            end else begin
                evKind = QAW_EV_BAD;
            end
        end else if (timeoutHit) begin
            evKind = QAW_EV_TIMEOUT;
        end
    end

    // Tick length is fixed at build time; software only sets the number of ticks
    // Window timer; any event restarts it so the next sequence begins at once
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            stepCnt  <= 16'h0;
            winTicks <= 10'h0;
        end else if (evKind != QAW_EV_NONE) begin
            stepCnt  <= 16'h0;
            winTicks <= 10'h0;
        end else if (stepCnt >= 16'(WIN_STEP_CYC - 1)) begin
            stepCnt  <= 16'h0;
            winTicks <= winTicks + 10'h1;
        end else begin
            stepCnt <= stepCnt + 16'h1;
        end
    end

    // A non-final byte that meets a time-out edge is dropped; the new sequence wants its first byte
    // Answer byte counter and accumulated value error
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            answerByteCounter <= `QAW_RST_ANSCNT;
            answerErr         <= 1'b0;
        end else if (evKind != QAW_EV_NONE) begin
            answerByteCounter <= `QAW_RST_ANSCNT;
            answerErr         <= 1'b0;
        end else if (answerWr) begin
            answerByteCounter <= answerByteCounter - 2'h1;
            answerErr         <= errNext;
        end
    end

    // Saturating, so a burst of bad events cannot wrap round to a clean count
    // Fail counter; good counts down, every other event counts up
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            sequenceFailCounter <= `QAW_RST_FAIL;
        end else begin
            case (evKind)
                QAW_EV_GOOD:    sequenceFailCounter <= fail_step(sequenceFailCounter, 1'b0);
                QAW_EV_BAD:     sequenceFailCounter <= fail_step(sequenceFailCounter, 1'b1);
                QAW_EV_TIMEOUT: sequenceFailCounter <= fail_step(sequenceFailCounter, 1'b1);
                QAW_EV_CFG:     sequenceFailCounter <= fail_step(sequenceFailCounter, 1'b1);
                default:        sequenceFailCounter <= sequenceFailCounter;
            endcase
        end
    end

    // Question generation only advances on a good event
    always_comb begin
        next_tokenCnt = tokenCnt;
        next_markov   = markov;
        if (evKind == QAW_EV_GOOD) begin
            next_tokenCnt = tokenCnt + 4'h1;
            if (tokenCnt == 4'hf) begin
                next_markov = markov_step(markov, questionFeedbackSelect);
            end
        end
    end

    // Question kept in a register so the readout is a flip-flop, in step with the counter
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            tokenCnt <= 4'h0;
            markov   <= 4'h0;
            question <= 4'h0;
        end else begin
            tokenCnt <= next_tokenCnt;
            markov   <= next_markov;
            question <= next_tokenCnt ^ next_markov;
        end
    end

    // Status flags: every event rewrites all four to its own pattern
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            sequenceErrorFlag       <= 1'b0;
            windowConfigChangedFlag <= 1'b0;
            timeoutFlag             <= 1'b0;
            earlyFlag               <= 1'b0;
        end else begin
            case (evKind)
                QAW_EV_GOOD: begin
                    sequenceErrorFlag       <= 1'b0;
                    windowConfigChangedFlag <= 1'b0;
                    timeoutFlag             <= 1'b0;
                    earlyFlag               <= 1'b0;
                end
                QAW_EV_BAD: begin
                    // Correct but early leaves sequence error clear, as the status table shows
                    sequenceErrorFlag       <= errNext;
                    windowConfigChangedFlag <= 1'b0;
                    timeoutFlag             <= 1'b0;
                    earlyFlag               <= inOpen;
                end
                QAW_EV_TIMEOUT: begin
                    sequenceErrorFlag       <= answerErr;
                    windowConfigChangedFlag <= 1'b0;
                    timeoutFlag             <= 1'b1;
                    earlyFlag               <= 1'b0;
                end
                QAW_EV_CFG: begin
                    sequenceErrorFlag       <= 1'b0;
                    windowConfigChangedFlag <= 1'b1;
                    timeoutFlag             <= 1'b0;
                    earlyFlag               <= 1'b0;
                end
                default: begin
                    sequenceErrorFlag       <= sequenceErrorFlag;
                    windowConfigChangedFlag <= windowConfigChangedFlag;
                    timeoutFlag             <= timeoutFlag;
                    earlyFlag               <= earlyFlag;
                end
            endcase
        end
    end

    // Window lengths; a locked write is dropped but still restarts the sequence
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            openLen  <= `QAW_RST_WINLEN;
            closeLen <= `QAW_RST_WINLEN;
        end else if (windowWr && !cfgLock) begin
            if (paddr == `QAW_ADDR_OPENWIN) begin
                openLen <= pwdata[7:0];
            end else begin
                closeLen <= pwdata[7:0];
            end
        end
    end

    // Plain control registers
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            questionFeedbackSelect <= 2'h0;
            cfgLock                <= 1'b0;
            irqEnable              <= 4'h0;
        end else if (accessWr) begin
            case (paddr)
                `QAW_ADDR_FDBK:  questionFeedbackSelect <= pwdata[1:0];
                `QAW_ADDR_CTRL:  cfgLock                <= pwdata[0];
                `QAW_ADDR_INTEN: irqEnable              <= pwdata[3:0];
                default:         cfgLock                <= cfgLock;
            endcase
        end
    end

    // Sticky interrupt bits; a new event wins over a clear in the same cycle
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            irqStatus <= 4'h0;
        end else begin
            irqStatus <= (irqStatus & ~((accessWr && paddr == `QAW_ADDR_INTCLR) ?
                                        pwdata[3:0] : 4'h0))
                       | {evKind == QAW_EV_CFG, evKind == QAW_EV_TIMEOUT,
                          evKind == QAW_EV_BAD, evKind == QAW_EV_GOOD};
        end
    end

    // Unmapped offsets answer zero with an error; writes to read-only words do nothing
    // Read mux and address map check
    always_comb begin
        next_rdata = 32'h0;
        mapped     = 1'b1;
        case (paddr)
            `QAW_ADDR_ANSWER:   next_rdata = 32'h0;
            `QAW_ADDR_QUESTION: next_rdata = {28'h0, question};
            `QAW_ADDR_STATUS: begin
                next_rdata[`QAW_ST_EARLY]   = earlyFlag;
                next_rdata[`QAW_ST_TIMEOUT] = timeoutFlag;
                next_rdata[`QAW_ST_SEQERR]  = sequenceErrorFlag;
                next_rdata[`QAW_ST_CFGCHG]  = windowConfigChangedFlag;
                next_rdata[`QAW_ST_CNT_LO +: 2]  = answerByteCounter;
                next_rdata[`QAW_ST_ANSERR]  = answerErr;
                next_rdata[`QAW_ST_FAIL_LO +: 3] = sequenceFailCounter;
            end
            `QAW_ADDR_OPENWIN:  next_rdata = {24'h0, openLen};
            `QAW_ADDR_CLOSEWIN: next_rdata = {24'h0, closeLen};
            `QAW_ADDR_FDBK:     next_rdata = {30'h0, questionFeedbackSelect};
            `QAW_ADDR_CTRL:     next_rdata = {31'h0, cfgLock};
            `QAW_ADDR_INTSTAT:  next_rdata = {28'h0, irqStatus};
            `QAW_ADDR_INTCLR:   next_rdata = 32'h0;
            `QAW_ADDR_INTEN:    next_rdata = {28'h0, irqEnable};
            default:            mapped     = 1'b0;
        endcase
    end

    // Read data and error captured in setup so both come from flip-flops
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            prdata  <= 32'h0;
            pslverr <= 1'b0;
        end else if (psel && !penable) begin
            prdata  <= pwrite ? 32'h0 : next_rdata;
            pslverr <= !mapped;
        end
    end
endmodule : qaw_event_evaluator
`default_nettype wire

// ---- hw/qaw_params.svh ----
// Register map, field positions, reset values and timing counts of the Q&A watchdog evaluator
`ifndef QAW_PARAMS_SVH
`define QAW_PARAMS_SVH

// Register byte addresses
`define QAW_ADDR_ANSWER    8'h00
`define QAW_ADDR_QUESTION  8'h04
`define QAW_ADDR_STATUS    8'h08
`define QAW_ADDR_OPENWIN   8'h0c
`define QAW_ADDR_CLOSEWIN  8'h10
`define QAW_ADDR_FDBK      8'h14
`define QAW_ADDR_CTRL      8'h18
`define QAW_ADDR_INTSTAT   8'h1c
`define QAW_ADDR_INTCLR    8'h20
`define QAW_ADDR_INTEN     8'h24

// Status register fields
`define QAW_ST_EARLY       0
`define QAW_ST_TIMEOUT     1
`define QAW_ST_SEQERR      2
`define QAW_ST_CFGCHG      3
`define QAW_ST_CNT_LO      4
`define QAW_ST_ANSERR      6
`define QAW_ST_FAIL_LO     8

// Interrupt bits
`define QAW_IRQ_GOOD       0
`define QAW_IRQ_BAD        1
`define QAW_IRQ_TIMEOUT    2
`define QAW_IRQ_CFG        3

// Reset values
`define QAW_RST_ANSCNT     2'h3
`define QAW_RST_FAIL       3'h0
`define QAW_RST_WINLEN     8'h01

// Window step timing
`define QAW_CLK_PERIOD_NS  10
`define QAW_WIN_STEP_NS    1000
`define QAW_WIN_STEP_CYC   (`QAW_WIN_STEP_NS / `QAW_CLK_PERIOD_NS)

`endif

// ---- hw/qaw_pkg.sv ----
// Types shared by the Q&A watchdog evaluator
package qaw_pkg;
    typedef logic [7:0] qaw_byte_t;
    typedef logic [3:0] qaw_nibble_t;
    typedef enum logic [2:0] {
        QAW_EV_NONE,
        QAW_EV_GOOD,
        QAW_EV_BAD,
        QAW_EV_TIMEOUT,
        QAW_EV_CFG
    } qaw_event_e;
endpackage : qaw_pkg

// ---- verification/qaw_mcu_model.sv ----
// Microcontroller model: APB master that writes watchdog answers
`include "qaw_params.svh"
`timescale 1ns/100ps
`default_nettype none
module qaw_mcu_model (
    input  wire logic        clk_sys, // System clock
    input  wire logic        pready,  // Slave ready
    input  wire logic [31:0] prdata,  // Read data
    input  wire logic        pslverr, // Slave error
    output logic             psel,    // Select
    output logic             penable, // Access phase
    output logic             pwrite,  // Direction
    output logic [7:0]       paddr,   // Byte address
    output logic [31:0]      pwdata   // Write data
);
    // First-answer column; the other three follow by nibble inversion
    logic [7:0] firstAns [16] = '{8'hff, 8'hb0, 8'he9, 8'ha6, 8'h75, 8'h3a, 8'h63, 8'h2c,
                                  8'hd2, 8'h9d, 8'hc4, 8'h8b, 8'h58, 8'h17, 8'h4e, 8'h01};

    initial begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 8'h00;
        pwdata  = 32'h0;
    end

    // One transfer, held until pready is seen; an idle cycle keeps drives single per step
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] rd, output logic err);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        pwdata  <= ~d;
        @(posedge clk_sys);
    endtask : xfer

    // Reference byte for question q at answer count c
    function automatic logic [7:0] ref_byte(input logic [3:0] q, input logic [1:0] c);
        return firstAns[q] ^ (c[0] ? 8'h00 : 8'hf0) ^ (c[1] ? 8'h00 : 8'h0f);
    endfunction : ref_byte

    // Answers for counts hi down to lo, in order; gap idles before the final byte
    task automatic answer(input logic [3:0] q, input int hi, input int lo, input int bad,
                          input int gap);
        logic [31:0] rd;
        logic        err;
        for (int c = hi; c >= lo; c--) begin
            if (c == 0) repeat (gap) @(posedge clk_sys);
            xfer(1'b1, `QAW_ADDR_ANSWER,
                 {24'h0, ref_byte(q, c[1:0]) ^ ((c == bad) ? 8'h01 : 8'h00)}, rd, err);
        end
    endtask : answer
endmodule : qaw_mcu_model
`default_nettype wire

// ---- verification/qaw_event_evaluator_chk.sv ----
// Port assertions for the Q&A watchdog evaluator
`include "qaw_params.svh"
`timescale 1ns/100ps
`default_nettype none
module qaw_event_evaluator_chk #(
    parameter int WIN_STEP_CYC = 100 // Window tick length in clocks
) (
    input wire logic                 clk_sys, // System clock
    input wire logic                 reset_n, // Async reset, active low
    input wire logic                 psel,    // APB select
    input wire logic                 penable, // APB access phase
    input wire logic                 pwrite,  // APB direction
    input wire logic [7:0]           paddr,   // APB address
    input wire logic [31:0]          pwdata,  // APB write data
    input wire logic                 pready,  // APB ready
    input wire logic [31:0]          prdata,  // APB read data
    input wire logic                 pslverr, // APB error
    input wire logic                 irq,     // Interrupt
    input wire qaw_pkg::qaw_nibble_t question // Current question
);
    import qaw_pkg::*;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    // Final-answer column, kept apart from the model's derivation as a cross-check
    logic [7:0] lastAns [16] = '{8'h00, 8'h4f, 8'h16, 8'h59, 8'h8a, 8'hc5, 8'h9c, 8'hd3,
                                 8'h2d, 8'h62, 8'h3b, 8'h74, 8'ha7, 8'he8, 8'hb1, 8'hfe};
    logic stRd;
    logic ansWr;
    logic cfgWr;

    // Access-phase decodes
    assign stRd  = psel && penable && !pwrite && paddr == `QAW_ADDR_STATUS;
    assign ansWr = psel && penable && pwrite && paddr == `QAW_ADDR_ANSWER;
    assign cfgWr = psel && penable && pwrite &&
                   (paddr == `QAW_ADDR_OPENWIN || paddr == `QAW_ADDR_CLOSEWIN);

    a_q_only_answer: assert property ($changed(question) |-> $past(ansWr))
        else $error("question moved without an answer write");
    a_q_good_ref: assert property ($changed(question) |->
                                   $past(pwdata[7:0]) == lastAns[$past(question)])
        else $error("question moved after a wrong final byte");
    a_cfg_keeps_q: assert property (cfgWr |=> $stable(question))
        else $error("window write changed the question");
    a_cfg_alone: assert property (stRd && prdata[3] |-> prdata[2:0] == 3'b000)
        else $error("config flag with other flags set");
    a_timeout_late: assert property (stRd && prdata[1] |-> !prdata[0] && !prdata[3])
        else $error("timeout with early or config flag");
    a_bad_counts: assert property (stRd && prdata[3:0] != 4'h0 |-> prdata[10:8] != 3'h0)
        else $error("bad event with fail count zero");
    a_ready_access: assert property (psel && penable |-> pready)
        else $error("no ready in access phase");
    a_unmapped_err: assert property (psel && penable |->
        pslverr == (paddr > `QAW_ADDR_INTEN || paddr[1:0] != 2'h0))
        else $error("error response does not match the address map");
endmodule : qaw_event_evaluator_chk

bind qaw_event_evaluator qaw_event_evaluator_chk #(.WIN_STEP_CYC(WIN_STEP_CYC)) chk_u (
    .clk_sys(clk_sys), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .irq(irq), .question(question));
`default_nettype wire

// ---- verification/qaw_event_evaluator_bench.sv ----
// Self-checking bench for the Q&A watchdog evaluator
`include "qaw_params.svh"
`timescale 1ns/100ps
`default_nettype none
module qaw_event_evaluator_bench;
    import qaw_pkg::*;
    logic        clk_sys, reset_n, psel, penable, pwrite, pready, pslverr, irq, err;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    qaw_nibble_t question;
    int          failures = 0, cmp_count = 0, cycles = 0, failExp = 0;

    // Short window ticks keep each sequence under a hundred cycles
    qaw_event_evaluator #(.WIN_STEP_CYC(2)) dut_u (.clk_sys(clk_sys), .reset_n(reset_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .pslverr(pslverr), .irq(irq), .question(question));
    qaw_mcu_model mcu_u (.clk_sys(clk_sys), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata));

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // Hang guard; the full run needs under two thousand cycles
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            failures++;
            results();
        end
    end

    task automatic results();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : results

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    // Saturating fail count expectation
    task automatic bump(input logic up);
        if (up) failExp = (failExp < 7) ? failExp + 1 : 7;
        else failExp = (failExp > 0) ? failExp - 1 : 0;
    endtask : bump

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        mcu_u.xfer(1'b0, a, 32'h0, rd, err);
        check(rd, exp);
    endtask : rdc

    // Status with counter back at 3; accumulated value error bit is masked
    task automatic status(input logic [3:0] fl);
        mcu_u.xfer(1'b0, `QAW_ADDR_STATUS, 32'h0, rd, err);
        check(rd & 32'hffff_ffbf, {21'h0, failExp[2:0], 4'h3, fl});
    endtask : status

    task automatic cfg(input logic [7:0] a, input logic [31:0] d);
        logic [3:0] q;
        q = question;
        mcu_u.xfer(1'b1, a, d, rd, err);
        bump(1'b1);
        status(4'h8);
        check({28'h0, question}, {28'h0, q});
    endtask : cfg

    // Answers hi..lo, a time-out wait if the sequence is left short, then the outcome
    task automatic seq(input int hi, input int lo, input int bad, input int gap,
                       input logic [3:0] fl);
        logic [3:0] q;
        q = question;
        mcu_u.answer(q, hi, lo, bad, gap);
        if (lo > 0) repeat (100) @(posedge clk_sys);
        bump(fl != 4'h0);
        status(fl);
        check({28'h0, question}, {28'h0, (fl == 4'h0) ? q + 4'h1 : q});
    endtask : seq

    initial begin
        reset_n = 1'b0;
        repeat (5) @(posedge clk_sys);
        reset_n <= 1'b1;
        @(posedge clk_sys);
        status(4'h0);
        cfg(`QAW_ADDR_OPENWIN, 32'd20);
        cfg(`QAW_ADDR_CLOSEWIN, 32'd20);
        rdc(`QAW_ADDR_OPENWIN, 32'd20);
        seq(3, 0, -1, 45, 4'h0);
        mcu_u.answer(question, 3, 3, -1, 0);
        mcu_u.xfer(1'b0, `QAW_ADDR_STATUS, 32'h0, rd, err);
        check({30'h0, rd[5:4]}, 32'h2);
        seq(2, 0, -1, 0, 4'h1);
        seq(3, 0, 2, 45, 4'h4);
        seq(3, 0, 3, 0, 4'h5);
        seq(3, 1, -1, 0, 4'h2);
        seq(3, 3, 3, 0, 4'h6);
        mcu_u.xfer(1'b1, `QAW_ADDR_CTRL, 32'h1, rd, err);
        cfg(`QAW_ADDR_OPENWIN, 32'd9);
        cfg(`QAW_ADDR_CLOSEWIN, 32'd9);
        rdc(`QAW_ADDR_OPENWIN, 32'd20);
        mcu_u.xfer(1'b1, `QAW_ADDR_CTRL, 32'h0, rd, err);
        // Every event class has fired at least once; only enabled bits reach the pin
        rdc(`QAW_ADDR_INTSTAT, 32'hf);
        check({31'h0, irq}, 32'h0);
        mcu_u.xfer(1'b1, `QAW_ADDR_INTEN, 32'h4, rd, err);
        check({31'h0, irq}, 32'h1);
        mcu_u.xfer(1'b1, `QAW_ADDR_INTCLR, 32'h4, rd, err);
        check({31'h0, irq}, 32'h0);
        rdc(`QAW_ADDR_INTSTAT, 32'hb);
        mcu_u.xfer(1'b1, `QAW_ADDR_FDBK, 32'h3, rd, err);
        rdc(`QAW_ADDR_FDBK, 32'h3);
        rdc(8'h30, 32'h0);
        check({31'h0, err}, 32'h1);
        results();
    end
endmodule : qaw_event_evaluator_bench
`default_nettype wire
